// file: pkg/serial_mode_pkg.sv
// constants and types for the serial mode and transmit control block
package serial_mode_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_LINE_MODE = 4'h0;
  localparam logic [3:0] ADDR_TX_CTRL   = 4'h1;
  localparam logic [3:0] ADDR_TX_SYNC   = 4'h2;
  localparam logic [3:0] ADDR_RX_SYNC   = 4'h3;
  localparam logic [3:0] ADDR_AUX       = 4'h4;
  localparam logic [3:0] ADDR_RX_CFG    = 4'h5;
  localparam logic [3:0] ADDR_TX_DATA   = 4'h6;
  localparam logic [3:0] ADDR_RX_DATA   = 4'h7;
  localparam logic [3:0] ADDR_STATUS    = 4'h8;

  localparam logic [7:0] LINE_MODE_RESET = 8'h04;
  localparam logic [7:0] TX_CTRL_RESET   = 8'h00;
  localparam logic [7:0] AUX_RESET       = 8'h00;
  localparam logic [7:0] RX_CFG_RESET    = 8'h00;

  // line_mode_params fields
  localparam int LM_RATE = 6;
  localparam int LM_SMODE = 4;
  localparam int LM_STOP = 2;
  localparam int LM_EVEN = 1;
  localparam int LM_PAR_EN = 0;
  // transmit_controls fields
  localparam int TC_DTR = 7;
  localparam int TC_LEN = 5;
  localparam int TC_BREAK = 4;
  localparam int TC_TX_EN = 3;
  localparam int TC_CRC16 = 2;
  localparam int TC_RTS = 1;
  localparam int TC_CRC_EN = 0;
  // aux_config fields
  localparam int AX_SYNC6 = 0;
  localparam int AX_PRESET1 = 1;
  localparam int AX_CRYSTAL = 2;
  localparam int AX_LOOP = 3;
  localparam int AX_ECHO = 4;
  localparam int AX_AUTO_EN = 5;
  localparam int AX_REQ_MODE = 6;
  localparam int AX_LOAD_INH = 7;
  // rx_config fields
  localparam int RC_LEN = 0;
  localparam int RC_RX_EN = 2;
  localparam int RC_HUNT = 3;
  // status fields
  localparam int ST_TX_EMPTY = 0;
  localparam int ST_SYNCED = 1;
  localparam int ST_RX_AVAIL = 2;
  localparam int ST_PAR_ERR = 3;
  localparam int ST_FRM_ERR = 4;
  localparam int ST_TX_IDLE = 5;

  localparam logic [1:0] STOP_SYNC = 2'b00;
  localparam logic [1:0] STOP_1P5  = 2'b10;
  localparam logic [1:0] STOP_2    = 2'b11;
  localparam logic [1:0] SM_MONO   = 2'b00;
  localparam logic [1:0] SM_BISYNC = 2'b01;
  localparam logic [1:0] SM_SDLC   = 2'b10;
  localparam logic [1:0] SM_EXT    = 2'b11;
  localparam logic [1:0] LEN_7     = 2'b01;
  localparam logic [1:0] LEN_6     = 2'b10;
  localparam logic [1:0] LEN_8     = 2'b11;
  localparam logic [6:0] DIV_1X    = 7'h01;
  localparam logic [6:0] DIV_16X   = 7'h10;
  localparam logic [6:0] DIV_32X   = 7'h20;
  localparam logic [6:0] DIV_64X   = 7'h40;

  localparam logic [7:0]  SDLC_FLAG  = 8'h7e;
  localparam logic [15:0] CRC16_POLY = 16'h8005;
  localparam logic [15:0] SDLC_POLY  = 16'h1021;

  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_STOP} tx_state_t;
  typedef enum logic [1:0] {TK_DATA, TK_CRC, TK_FILL} tx_kind_t;
  typedef enum logic [2:0] {RX_OFF, RX_HUNT, RX_SYNC, RX_AIDLE, RX_ABITS} rx_state_t;
endpackage

// file: core/serial_mode_tx_control.sv
// per-channel mode, transmitter and sync and async receiver logic of a serial controller
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module serial_mode_tx_control
  import serial_mode_pkg::*;
(
  input  wire logic                              clock,
  input  wire logic                              rst_n,
  input  wire logic [serial_mode_pkg::ADDR_W-1:0] addr,
  input  wire logic [7:0]                        wr_data,
  input  wire logic                              wr_en,
  input  wire logic                              rd_en,
  output logic      [7:0]                        rd_data,
  input  wire logic                              tx_clk,
  input  wire logic                              rx_clk,
  input  wire logic                              rxd,
  input  wire logic                              sync_n,
  output logic                                   txd,
  output logic                                   rts_n,
  output logic                                   dtr_req_n
);
  import serial_mode_pkg::*;

  logic [7:0] line_mode_params, transmit_controls, tx_sync_or_address, rx_sync_or_flag;
  logic [7:0] aux_config, rx_config, tx_buf, rx_char;
  logic       buf_full, rx_avail, par_err, frm_err;
  logic [2:0] txc_s, rxc_s;
  logic [1:0] rxd_s, sync_s;
  tx_state_t  tx_state;
  tx_kind_t   tx_kind;
  rx_state_t  rx_state;
  logic [15:0] tx_sh, rx_sh, crc;
  logic [4:0]  tx_left;
  logic [7:0]  tx_cnt, rx_cnt, rx_tgt;
  logic [3:0]  rx_idx;
  logic [9:0]  rx_acc;
  logic        crc_on, crc_pending, brk_active;

  wire wr_line = wr_en && addr == ADDR_LINE_MODE;
  wire wr_tctl = wr_en && addr == ADDR_TX_CTRL;
  wire wr_txd  = wr_en && addr == ADDR_TX_DATA;
  wire [1:0] rate  = line_mode_params[LM_RATE+:2];
  wire [1:0] smode = line_mode_params[LM_SMODE+:2];
  wire [1:0] stopc = line_mode_params[LM_STOP+:2];
  wire par_en = line_mode_params[LM_PAR_EN];
  wire even   = line_mode_params[LM_EVEN];
  wire tx_en  = transmit_controls[TC_TX_EN];
  wire sync6  = aux_config[AX_SYNC6];
  // sync mode field only counts in synchronous operation
  wire is_sync = stopc == STOP_SYNC;
  wire ext     = is_sync && smode == SM_EXT;
  wire sdlc    = is_sync && (smode == SM_SDLC || (ext && rate == 2'b11));
  wire bisync  = is_sync && smode == SM_BISYNC;
  wire mono_rx = is_sync && smode == SM_MONO;
  wire tx_edge = txc_s[1] && !txc_s[2];
  wire rx_edge = rxc_s[1] && !rxc_s[2];

  // link clocks and pins: second stage read only after the first
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      txc_s <= 3'h0;
      rxc_s <= 3'h0;
      rxd_s <= 2'h3;
      sync_s <= 2'h3;
    end
    else
    begin
      txc_s <= {txc_s[1:0], tx_clk};
      rxc_s <= {rxc_s[1:0], rx_clk};
      rxd_s <= {rxd_s[0], rxd};
      sync_s <= {sync_s[0], sync_n};
    end

  logic [6:0] div;
  always_comb
  begin
    case (rate)
      2'b00: div = DIV_1X;
      2'b01: div = DIV_16X;
      2'b10: div = DIV_32X;
      default: div = DIV_64X;
    endcase
    if (is_sync && !ext)
      div = DIV_1X;
  end
  wire [7:0] div8 = {1'b0, div};
  // 1.5 stop bits degrade to one at 1x since half a clock does not exist
  wire [7:0] stop_span = stopc == STOP_1P5 ? div8 + (div8 >> 1) :
                         stopc == STOP_2 ? {div8[6:0], 1'b0} : div8;
  wire [7:0] tx_span = tx_state == TX_STOP ? stop_span : div8;
  // a drop to a lower ratio mid-count must end the bit at once, not after a counter wrap
  wire bit_end = tx_edge && tx_cnt >= tx_span - 8'h01;

  function automatic logic [3:0] char_bits(input logic [1:0] len, input logic [7:0] d);
    case (len)
      LEN_7: char_bits = 4'h7;
      LEN_6: char_bits = 4'h6;
      LEN_8: char_bits = 4'h8;
      default:
        if (!d[7]) char_bits = 4'h5;
        else if (!d[6]) char_bits = 4'h4;
        else if (!d[5]) char_bits = 4'h3;
        else if (!d[4]) char_bits = 4'h2;
        else char_bits = 4'h1;
    endcase
  endfunction

  // character frame: data right-justified, parity directly above it
  wire [3:0]  tx_n    = char_bits(transmit_controls[TC_LEN+:2], tx_buf);
  wire [7:0]  tx_mask = 8'hff >> (4'h8 - tx_n);
  wire [7:0]  tx_dat  = tx_buf & tx_mask;
  wire        tx_par  = even ? ^tx_dat : ~^tx_dat;
  wire [15:0] tx_char = {8'h00, tx_dat} | (par_en ? {15'h0000, tx_par} << tx_n : 16'h0000);
  wire [4:0]  tx_clen = {1'b0, tx_n} + {4'h0, par_en};
  wire [15:0] fill = sdlc ? {8'h00, SDLC_FLAG} : bisync ? {rx_sync_or_flag, tx_sync_or_address} :
                     {8'h00, tx_sync_or_address};
  wire [4:0]  fill_len = sdlc ? 5'h08 : bisync ? 5'h10 : sync6 ? 5'h06 : 5'h08;
  wire [15:0] poly = transmit_controls[TC_CRC16] ? CRC16_POLY : SDLC_POLY;
  wire abort_crc = tx_state == TX_SHIFT && tx_kind == TK_CRC && !tx_en;
  wire take_char = buf_full && tx_en;
  wire send_crc = is_sync && crc_pending && transmit_controls[TC_CRC_EN] && tx_en;
  wire reload = bit_end && (tx_state != TX_SHIFT || tx_left == 5'h01 || abort_crc);
  wire load = reload && !(tx_state == TX_SHIFT && !is_sync && tx_kind == TK_DATA && !abort_crc);
  wire shift_crc = bit_end && tx_state == TX_SHIFT && tx_kind == TK_DATA && crc_on;

  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      tx_cnt <= 8'h00;
    else if (bit_end)
      tx_cnt <= 8'h00;
    else if (tx_edge)
      tx_cnt <= tx_cnt + 8'h01;

  // transmit shifter; a started unit runs to its end, except a crc cut short when transmit enable drops
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      tx_state <= TX_IDLE;
      tx_kind <= TK_DATA;
      tx_sh <= 16'hffff;
      tx_left <= 5'h00;
      crc_on <= 1'b0;
    end
    else if (bit_end && tx_state == TX_SHIFT && !reload)
    begin
      tx_sh <= {1'b1, tx_sh[15:1]};
      tx_left <= tx_left - 5'h01;
    end
    else if (reload && !load)
      tx_state <= TX_STOP;
    else if (load)
    begin
      tx_state <= TX_SHIFT;
      if (abort_crc)
      begin
        tx_kind <= TK_FILL;
        tx_sh <= fill;
        tx_left <= fill_len;
      end
      else if (take_char)
      begin
        tx_kind <= TK_DATA;
        crc_on <= transmit_controls[TC_CRC_EN];
        tx_sh <= is_sync ? tx_char : {tx_char[14:0], 1'b0};
        tx_left <= is_sync ? tx_clen : tx_clen + 5'h01;
      end
      else if (send_crc)
      begin
        tx_kind <= TK_CRC;
        tx_sh <= {<<{crc}};
        tx_left <= 5'h10;
      end
      else if (is_sync && tx_en)
      begin
        tx_kind <= TK_FILL;
        tx_sh <= fill;
        tx_left <= fill_len;
      end
      else
        tx_state <= TX_IDLE;
    end

  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      buf_full <= 1'b0;
    else if (wr_txd)
      buf_full <= 1'b1;
    else if (load && take_char && !abort_crc)
      buf_full <= 1'b0;

  // crc takes the line bits of marked characters lsb first, parity bit included
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      crc <= 16'h0000;
      crc_pending <= 1'b0;
    end
    else
    begin
      if (shift_crc)
        crc <= {crc[14:0], 1'b0} ^ ((crc[15] ^ tx_sh[0]) ? poly : 16'h0000);
      if (load && !abort_crc && take_char && transmit_controls[TC_CRC_EN] && !crc_pending)
      begin
        crc <= aux_config[AX_PRESET1] ? 16'hffff : 16'h0000;
        crc_pending <= 1'b1;
      end
      else if (load && !take_char && (send_crc || abort_crc))
        crc_pending <= 1'b0;
    end

  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      brk_active <= 1'b0;
    else if (tx_edge)
      brk_active <= transmit_controls[TC_BREAK];

  wire line_bit = tx_state == TX_SHIFT ? tx_sh[0] :
                  (!tx_en && (aux_config[AX_ECHO] || aux_config[AX_LOOP])) ? rxd_s[1] : 1'b1;
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      txd <= 1'b1;
      rts_n <= 1'b1;
      dtr_req_n <= 1'b1;
    end
    else
    begin
      txd <= brk_active ? 1'b0 : line_bit;
      rts_n <= !(transmit_controls[TC_RTS] || (!is_sync && aux_config[AX_AUTO_EN] &&
                 (tx_state != TX_IDLE || buf_full)));
      dtr_req_n <= aux_config[AX_REQ_MODE] ? !(tx_en && !buf_full) :
                   !transmit_controls[TC_DTR];
    end

  // receiver: hunt and character assembly in sync modes, start-bit framing in async
  wire rx_en = rx_config[RC_RX_EN];
  wire rx_bit = rx_edge && rx_cnt >= div8 - 8'h01;
  wire [15:0] rx_nsh = {rxd_s[1], rx_sh[15:1]};
  wire pin_hit = !aux_config[AX_CRYSTAL] && !sync_s[1];
  wire m8 = sync6 ? rx_nsh[15:10] == rx_sync_or_flag[5:0] : rx_nsh[15:8] == rx_sync_or_flag;
  wire mbi = sync6 ? rx_nsh[15:4] == {rx_sync_or_flag[5:0], tx_sync_or_address[5:0]} :
             rx_nsh == {rx_sync_or_flag, tx_sync_or_address};
  wire flag_hit = rx_nsh[15:8] == rx_sync_or_flag;
  logic hunt_hit;
  always_comb
  begin
    hunt_hit = 1'b0;
    if (ext)
      case (rate)
        2'b10: hunt_hit = pin_hit || m8;
        2'b11: hunt_hit = pin_hit || flag_hit;
        default: hunt_hit = pin_hit;
      endcase
    else if (sdlc)
      hunt_hit = flag_hit;
    else if (bisync)
      hunt_hit = mbi;
    else
      hunt_hit = m8;
  end
  wire [3:0] rx_n = char_bits(rx_config[RC_LEN+:2], 8'hff);
  wire [3:0] rx_tot = rx_n + {3'h0, par_en};
  wire [7:0] rx_dmask = 8'hff >> (4'h8 - rx_n);
  wire [7:0] rx_keep = rx_n == 4'h8 ? 8'hff : 8'hff >> (4'h8 - rx_tot);
  wire [7:0] rx_pmask = rx_acc[7:0] & rx_dmask;
  wire rx_pexp = even ? ^rx_pmask : ~^rx_pmask;
  wire hunt_cmd = wr_en && addr == ADDR_RX_CFG && wr_data[RC_HUNT];
  wire drop = (mono_rx && aux_config[AX_LOAD_INH] && rx_nsh[15:8] == tx_sync_or_address) ||
              (sdlc && flag_hit);
  logic rx_put, rx_perr, rx_ferr, synced_now;
  logic [7:0] rx_val;

  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      rx_state <= RX_OFF;
      rx_cnt <= 8'h00;
      rx_tgt <= 8'h00;
      rx_idx <= 4'h0;
      rx_sh <= 16'h0000;
      rx_acc <= 10'h000;
      rx_put <= 1'b0;
      rx_perr <= 1'b0;
      rx_ferr <= 1'b0;
      rx_val <= 8'h00;
      synced_now <= 1'b0;
    end
    else
    begin
      rx_put <= 1'b0;
      synced_now <= 1'b0;
      if (!rx_en)
        rx_state <= RX_OFF;
      else
        case (rx_state)
          RX_OFF, RX_HUNT:
          begin
            if (!is_sync)
              rx_state <= RX_AIDLE;
            else if (rx_state == RX_OFF)
              rx_state <= RX_HUNT;
            else if (rx_bit && hunt_hit)
            begin
              rx_state <= RX_SYNC;
              rx_idx <= 4'h0;
              synced_now <= 1'b1;
            end
          end
          RX_SYNC:
            if (hunt_cmd || !is_sync)
              rx_state <= RX_OFF;
            else if (rx_bit && ((sdlc && flag_hit) || (ext && rate == 2'b11 && pin_hit)))
              rx_idx <= 4'h0;
            else if (rx_bit)
            begin
              rx_idx <= rx_idx == 4'h7 ? 4'h0 : rx_idx + 4'h1;
              if (rx_idx == 4'h7 && !drop)
              begin
                rx_val <= rx_nsh[15:8];
                rx_put <= 1'b1;
                rx_perr <= 1'b0;
                rx_ferr <= 1'b0;
              end
            end
          RX_AIDLE:
            if (is_sync)
              rx_state <= RX_OFF;
            else if (rx_edge && !rxd_s[1])
            begin
              rx_state <= RX_ABITS;
              rx_cnt <= 8'h00;
              rx_tgt <= (div8 >> 1) | 8'h01;
              // at 1x the detecting edge is already mid start bit, so the next sample is d0
              rx_idx <= div8 == 8'h01 ? 4'h1 : 4'h0;
            end
          RX_ABITS:
            if (rx_edge && rx_cnt == rx_tgt - 8'h01)
            begin
              rx_cnt <= 8'h00;
              rx_tgt <= div8;
              rx_idx <= rx_idx + 4'h1;
              if (rx_idx == 4'h0 && rxd_s[1])
                rx_state <= RX_AIDLE;
              else if (rx_idx == rx_tot + 4'h1)
              begin
                rx_state <= RX_AIDLE;
                rx_val <= rx_acc[7:0] & rx_keep | ~rx_keep;
                rx_put <= 1'b1;
                rx_perr <= par_en && rx_acc[rx_n] != rx_pexp;
                rx_ferr <= !rxd_s[1];
              end
              else if (rx_idx != 4'h0)
                rx_acc[rx_idx - 4'h1] <= rxd_s[1];
            end
            else if (rx_edge)
              rx_cnt <= rx_cnt + 8'h01;
          default:
            rx_state <= RX_OFF;
        endcase
      if (rx_state != RX_ABITS && rx_state != RX_AIDLE)
      begin
        if (rx_bit)
          rx_sh <= rx_nsh;
        if (rx_edge)
          rx_cnt <= rx_bit ? 8'h00 : rx_cnt + 8'h01;
      end
    end

  // software registers; a software write wins over the hardware clear of the break bit
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      line_mode_params <= LINE_MODE_RESET;
      transmit_controls <= TX_CTRL_RESET;
      tx_sync_or_address <= 8'h00;
      rx_sync_or_flag <= 8'h00;
      aux_config <= AUX_RESET;
      rx_config <= RX_CFG_RESET;
      tx_buf <= 8'h00;
    end
    else
    begin
      if (wr_line)
        line_mode_params <= wr_data;
      if (wr_tctl)
        transmit_controls <= wr_data;
      else if (synced_now && mono_rx && aux_config[AX_LOOP])
        transmit_controls[TC_BREAK] <= 1'b0;
      if (wr_en && addr == ADDR_TX_SYNC)
        tx_sync_or_address <= wr_data;
      if (wr_en && addr == ADDR_RX_SYNC)
        rx_sync_or_flag <= wr_data;
      if (wr_en && addr == ADDR_AUX)
        aux_config <= wr_data;
      if (wr_en && addr == ADDR_RX_CFG)
        rx_config <= {4'h0, wr_data[3:0] & 4'h7};
      if (wr_txd)
        tx_buf <= wr_data;
    end

  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      rx_char <= 8'h00;
      rx_avail <= 1'b0;
      par_err <= 1'b0;
      frm_err <= 1'b0;
    end
    else
    begin
      if (rx_put)
        rx_char <= rx_val;
      rx_avail <= rx_put || (rx_avail && !(rd_en && addr == ADDR_RX_DATA));
      par_err <= (rx_put && rx_perr) || (par_err && !(rd_en && addr == ADDR_STATUS));
      frm_err <= (rx_put && rx_ferr) || (frm_err && !(rd_en && addr == ADDR_STATUS));
    end

  logic [7:0] status;
  always_comb
  begin
    status = 8'h00;
    status[ST_TX_EMPTY] = !buf_full;
    status[ST_SYNCED] = rx_state == RX_SYNC;
    status[ST_RX_AVAIL] = rx_avail;
    status[ST_PAR_ERR] = par_err;
    status[ST_FRM_ERR] = frm_err;
    status[ST_TX_IDLE] = tx_state == TX_IDLE;
  end

  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      rd_data <= 8'h00;
    else if (rd_en)
      case (addr)
        ADDR_LINE_MODE: rd_data <= line_mode_params;
        ADDR_TX_CTRL: rd_data <= transmit_controls;
        ADDR_TX_SYNC: rd_data <= tx_sync_or_address;
        ADDR_RX_SYNC: rd_data <= rx_sync_or_flag;
        ADDR_AUX: rd_data <= aux_config;
        ADDR_RX_CFG: rd_data <= rx_config;
        ADDR_RX_DATA: rd_data <= rx_char;
        ADDR_STATUS: rd_data <= status;
        default: rd_data <= 8'h00;
      endcase
    else
      rd_data <= 8'h00;
endmodule
`default_nettype wire

// file: verif/serial_mode_tx_control_sva.sv
// concurrent checks on the ports of the serial mode and transmit control block
`timescale 1ns/1ps
`default_nettype none
module serial_mode_tx_control_sva
  import serial_mode_pkg::*;
(
  input wire logic                               clock,
  input wire logic                               rst_n,
  input wire logic [serial_mode_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0]                         wr_data,
  input wire logic                               wr_en,
  input wire logic                               rd_en,
  input wire logic [7:0]                         rd_data,
  input wire logic                               txd,
  input wire logic                               rts_n,
  input wire logic                               dtr_req_n
);
  logic [7:0] lm;
  logic [7:0] tc;
  logic [7:0] aux;
  logic       wrote_lm;
  logic [5:0] brk_age;
  logic [7:0] run;
  logic [8:0] idle;
  logic       one_x;
  logic       quiet;
  // bit times are only fixed here when the effective ratio is 1x
  assign one_x = lm[7:6] == 2'b00 || (lm[3:2] == STOP_SYNC && lm[5:4] != SM_EXT);
  assign quiet = !tc[TC_TX_EN] && !tc[TC_BREAK] && !aux[AX_LOOP] && !aux[AX_ECHO] && lm[3:2] != STOP_SYNC && one_x;

  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      lm       <= LINE_MODE_RESET;
      tc       <= TX_CTRL_RESET;
      aux      <= AUX_RESET;
      wrote_lm <= 1'b0;
    end
    else if (wr_en && addr == ADDR_LINE_MODE)
    begin
      lm       <= wr_data;
      wrote_lm <= 1'b1;
    end
    else if (wr_en && addr == ADDR_TX_CTRL)
      tc <= wr_data;
    else if (wr_en && addr == ADDR_AUX)
      aux <= wr_data;

  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      brk_age <= 6'h00;
      run     <= 8'hff;
      idle    <= 9'h000;
    end
    else
    begin
      brk_age <= !tc[TC_BREAK] ? 6'h00 : brk_age + {5'h00, brk_age != 6'h3f};
      run     <= $changed(txd) ? 8'h00 : run + {7'h00, run != 8'hff};
      idle    <= !quiet ? 9'h000 : idle + {8'h00, idle != 9'h1ff};
    end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence tc_wr;
    wr_en && addr == ADDR_TX_CTRL;
  endsequence
  sequence brk_wr;
    tc_wr ##0 wr_data[TC_BREAK];
  endsequence

  AST_RESET_IDLE:
    assert property ($rose(rst_n) |-> txd && rts_n && dtr_req_n) else $error("outputs not idle after reset");
  AST_MODE_RESET:
    assert property (rd_en && addr == ADDR_LINE_MODE && !wrote_lm |=> rd_data[2]) else $error("mode bit 2 not set");
  AST_RTS_PIN:
    assert property (tc_wr ##0 !(aux[AX_AUTO_EN] && lm[3:2] != STOP_SYNC) |-> ##3 rts_n == !$past(wr_data[TC_RTS], 3))
      else $error("rts pin does not follow its bit");
  AST_DTR_PIN:
    assert property (tc_wr ##0 !aux[AX_REQ_MODE] |-> ##3 dtr_req_n == !$past(wr_data[TC_DTR], 3))
      else $error("terminal ready pin does not follow its bit");
  AST_BREAK_ONSET:
    assert property (brk_wr |-> ##[1:40] !txd) else $error("break did not start");
  AST_BREAK_HOLD:
    assert property (tc[TC_BREAK] && !aux[AX_LOOP] && brk_age == 6'h3f |-> !txd) else $error("break not held");
  AST_BIT_TIME:
    assert property ($changed(txd) && !tc[TC_BREAK] && !aux[AX_LOOP] && !aux[AX_ECHO] && one_x |-> run >= 8'h1c)
      else $error("bit shorter than one link clock at 1x");
  AST_IDLE_MARK:
    assert property (idle == 9'h1f4 |-> txd) else $error("disabled transmitter not marking");
endmodule

bind serial_mode_tx_control serial_mode_tx_control_sva u_sva (
  .clock     (clock),
  .rst_n     (rst_n),
  .addr      (addr),
  .wr_data   (wr_data),
  .wr_en     (wr_en),
  .rd_en     (rd_en),
  .rd_data   (rd_data),
  .txd       (txd),
  .rts_n     (rts_n),
  .dtr_req_n (dtr_req_n)
);
`default_nettype wire

// file: verif/line_peer.sv
// serial peer: makes both link clocks, drives the receive line, captures frames
`timescale 1ns/1ps
`default_nettype none
module line_peer #(
  parameter int HALF_NS = 80
)(
  input  wire logic       txd,
  output logic            tx_clk,
  output logic            rx_clk,
  output logic            rxd,
  output logic [9:0]      seen,
  output logic            done
);
  logic busy;
  int   cnt;
  initial
  begin
    {tx_clk, rx_clk, busy, done, cnt} = '0;
    rxd  = 1'b1;
    seen = 10'h000;
    forever
    begin
      #(HALF_NS);
      tx_clk = ~tx_clk;
      rx_clk = ~rx_clk;
    end
  end
  // sample mid-bit; stays parked after ten bits until armed again
  always @(negedge tx_clk)
    if (busy)
    begin
      seen = {txd, seen[9:1]};
      cnt  = cnt + 1;
      busy = cnt < 10;
      done = !busy;
    end
    else if (!txd && !done)
    begin
      busy = 1'b1;
      cnt  = 0;
    end
  task automatic arm();
    done = 1'b0;
  endtask
  // one start, data and parity, one stop; line pulled up to mark after
  task automatic send(input logic [9:0] bits);
    for (int i = 0; i < 10; i++)
    begin
      @(negedge rx_clk);
      rxd = bits[i];
    end
    @(negedge rx_clk);
    rxd = 1'b1;
  endtask
endmodule
`default_nettype wire

// file: verif/serial_mode_tx_control_tb_top.sv
// self-checking testbench for the serial mode and transmit control block
`timescale 1ns/1ps
`default_nettype none
module serial_mode_tx_control_tb_top;
  import serial_mode_pkg::*;
  logic       clock, rst_n, wr_en, rd_en, sync_n, tx_clk, rx_clk, rxd, txd, rts_n, dtr_req_n, done;
  logic [3:0] addr;
  logic [7:0] wr_data, rd_data, rv;
  logic [9:0] seen;
  int         n_errors, checks_done, k, n;
  int         cyc = 0;
  logic [7:0] lm_t [5] = '{8'h07, 8'h0d, 8'h04, 8'h07, 8'h08};
  logic [7:0] tc_t [5] = '{8'h68, 8'h28, 8'h48, 8'h08, 8'h68};
  logic [7:0] dt_t [5] = '{8'ha5, 8'hb5, 8'hea, 8'hc5, 8'h00};
  logic [9:0] ex_t [5] = '{10'h2a5, 10'h3b5, 10'h3ea, 10'h3f5, 10'h300};

  serial_mode_tx_control u_serial_mode_tx_control (.clock(clock), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .tx_clk(tx_clk), .rx_clk(rx_clk), .rxd(rxd),
    .sync_n(sync_n), .txd(txd), .rts_n(rts_n), .dtr_req_n(dtr_req_n));
  line_peer u_line_peer (.txd(txd), .tx_clk(tx_clk), .rx_clk(rx_clk), .rxd(rxd), .seen(seen), .done(done));

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc = cyc + 1;
    if (cyc == 80000)
    begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (n_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic compare(input logic [9:0] seen_v, input logic [9:0] exp_v);
    checks_done++;
    if (seen_v !== exp_v)
    begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clock);
    wr_en   <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    @(negedge clock);
    d = rd_data;
  endtask
  // counts clocks until the line reaches a level, bounded
  task automatic wait_txd(input logic v, output int c);
    c = 0;
    while (txd !== v && c < 4000)
    begin
      @(posedge clock);
      c++;
    end
  endtask

  initial
  begin
    {rst_n, wr_en, rd_en, addr, wr_data, n_errors, checks_done} = '0;
    sync_n = 1'b1;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    rd(ADDR_LINE_MODE, rv);
    compare({2'b00, rv}, {2'b00, LINE_MODE_RESET});
    rd(4'hf, rv);
    compare({2'b00, rv}, 10'h000);
    wr(ADDR_TX_CTRL, 8'h82);
    repeat (4) @(negedge clock);
    compare({8'h00, rts_n, dtr_req_n}, 10'h000);
    wr(ADDR_TX_CTRL, 8'h00);
    repeat (4) @(negedge clock);
    compare({8'h00, rts_n, dtr_req_n}, 10'h003);
    wr(ADDR_AUX, 8'h40);
    wr(ADDR_TX_CTRL, 8'h80);
    repeat (4) @(negedge clock);
    compare({9'h000, dtr_req_n}, 10'h001);
    wr(ADDR_AUX, 8'h00);
    for (k = 0; k < 5; k++)
    begin
      wr(ADDR_LINE_MODE, lm_t[k]);
      wr(ADDR_TX_CTRL, tc_t[k]);
      u_line_peer.arm();
      wr(ADDR_TX_DATA, dt_t[k]);
      for (int i = 0; i < 2000 && !done; i++) @(posedge clock);
      compare(seen, ex_t[k]);
      repeat (200) @(posedge clock);
    end
    wr(ADDR_LINE_MODE, 8'h05);
    wr(ADDR_RX_CFG, 8'h05);
    u_line_peer.send({1'b1, 1'b1, 7'h35, 1'b0});
    repeat (40) @(posedge clock);
    rd(ADDR_RX_DATA, rv);
    compare({2'b00, rv}, 10'h0b5);
    wr(ADDR_LINE_MODE, 8'h04);
    wr(ADDR_AUX, 8'h20);
    wr(ADDR_TX_CTRL, 8'h6a);
    wr(ADDR_TX_DATA, 8'h55);
    repeat (40) @(posedge clock);
    wr(ADDR_TX_CTRL, 8'h68);
    repeat (4) @(negedge clock);
    compare({9'h000, rts_n}, 10'h000);
    repeat (600) @(negedge clock);
    compare({9'h000, rts_n}, 10'h001);
    wr(ADDR_AUX, 8'h00);
    for (k = 1; k < 4; k++)
    begin
      wr(ADDR_LINE_MODE, {k[1:0], 6'h04});
      wr(ADDR_TX_DATA, 8'hff);
      wait_txd(1'b0, n);
      wait_txd(1'b1, n);
      compare(10'((n + 16) >> 5), 10'(16 << (k - 1)));
      repeat (5632 << (k - 1)) @(posedge clock);
    end
    // sdlc idle fill: flags lsb first at the forced 1x ratio
    u_line_peer.arm();
    wr(ADDR_RX_SYNC, SDLC_FLAG);
    wr(ADDR_TX_SYNC, 8'h3c);
    wr(ADDR_LINE_MODE, 8'h20);
    for (int i = 0; i < 2000 && !done; i++) @(posedge clock);
    compare(seen, 10'h33f);
    wr(ADDR_LINE_MODE, 8'h04);
    wr(ADDR_TX_CTRL, 8'h10);
    repeat (80) @(negedge clock);
    compare({9'h000, txd}, 10'h000);
    wr(ADDR_TX_CTRL, 8'h00);
    repeat (600) @(negedge clock);
    compare({9'h000, txd}, 10'h001);
    print_verdict();
  end
endmodule
`default_nettype wire
